// ---- core/acq_ctrl_regs.svh ----
// offsets, field positions, reset value and read mask of the control block
`ifndef ACQ_CTRL_REGS_SVH
`define ACQ_CTRL_REGS_SVH

`define ACQ_CTRL_OFFSET 8'h04
`define ACQ_CTRL_RESET 16'h0000
`define ACQ_CTRL_RMASK 16'h3f3f
`define ACQ_FMT_BIT 0
`define ACQ_TRIG_LSB 1
`define ACQ_SRC_LSB 3
`define ACQ_SCAN_LSB 8
`define ACQ_TIMER_BIT 11
`define ACQ_IRQ_LSB 12
`define ACQ_ISR_OFFSET 8'h00
`define ACQ_ISR_EN_BIT 0
`define ACQ_ISR_REL_BIT 15

`endif

// ---- core/acq_ctrl_pkg.sv ----
// types for the acquisition control block
package acq_ctrl_pkg;
    typedef enum logic [1:0] {
        TRIG_OFF0 = 2'h0,
        TRIG_IN = 2'h1,
        TRIG_OUT = 2'h2,
        TRIG_OFF3 = 2'h3
    } trig_dir_t;
    typedef enum logic [2:0] {
        SRC_DIFF = 3'h0,
        SRC_SINGLE = 3'h1,
        SRC_UNUSED = 3'h2,
        SRC_CAL_4V9 = 3'h3,
        SRC_CAL_2V45 = 3'h4,
        SRC_CAL_1V225 = 3'h5,
        SRC_CAL_0V6125 = 3'h6,
        SRC_AUTO_ZERO = 3'h7
    } input_src_t;
    typedef enum logic [2:0] {
        SCAN_OFF = 3'h0,
        SCAN_UNI_CONT = 3'h1,
        SCAN_UNI_SINGLE = 3'h2,
        SCAN_BURST_CONT = 3'h3,
        SCAN_BURST_SINGLE = 3'h4,
        SCAN_EXT_ONLY = 3'h5,
        SCAN_UNUSED6 = 3'h6,
        SCAN_UNUSED7 = 3'h7
    } scan_mode_t;
    typedef enum logic [1:0] {
        IRQ_OFF0 = 2'h0,
        IRQ_EACH = 2'h1,
        IRQ_GROUP = 2'h2,
        IRQ_OFF3 = 2'h3
    } irq_cond_t;
    typedef enum logic [1:0] {
        IRQ_IDLE = 2'b01,
        IRQ_HELD = 2'b10
    } irq_state_t;
endpackage

// ---- core/acq_pin_sync.sv ----
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module acq_pin_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;

    // s1 only feeds s2; a change counts once s2 and s3 agree
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level_o <= s3;
            end
        end
    end
endmodule

// ---- core/acq_ctrl.sv ----
// acquisition control register with trigger, source, scan and interrupt decode
`timescale 1ns/1ps
`include "acq_ctrl_regs.svh"
module acq_ctrl
    import acq_ctrl_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic [1:0] BE_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic CONV_DONE_I,
    input wire logic GROUP_DONE_I,
    input wire logic TIMER_TICK_I,
    input wire logic [15:0] RAW_I,
    input wire logic TRIG_PIN_I,
    output logic [15:0] RDATA_O,
    output logic [15:0] RESULT_O,
    output logic [2:0] SRC_SEL_O,
    output logic CAL_SEL_O,
    output logic TRIG_PIN_O,
    output logic TRIG_PIN_OEN_O,
    output logic CONV_START_O,
    output logic SCAN_ACTIVE_O,
    output logic IRQ_O
);
    // ************************************************************
    // register state
    // ************************************************************
    logic [15:0] ctrl;
    logic int_en;
    irq_state_t irq_state;
    irq_state_t next_irq_state;
    logic trig_level;
    logic trig_prev;
    logic [15:0] lane_mask;
    genvar lane;

    // ************************************************************
    // byte lanes
    // ************************************************************
    generate
        for (lane = 0; lane < 2; lane++) begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{BE_I[lane]}};
        end
    endgenerate

    // ************************************************************
    // decode
    // ************************************************************
    wire hit_ctrl = (ADDR_I == `ACQ_CTRL_OFFSET);
    wire hit_isr = (ADDR_I == `ACQ_ISR_OFFSET);
    wire wr_ctrl = WR_I && hit_ctrl;
    wire wr_isr = WR_I && hit_isr;
    wire [15:0] next_ctrl = ((ctrl & ~lane_mask) | (WDATA_I & lane_mask))
        & `ACQ_CTRL_RMASK;
    wire fmt_straight = ctrl[`ACQ_FMT_BIT];
    trig_dir_t trig_dir;
    input_src_t src;
    scan_mode_t scan;
    irq_cond_t irq_cond;
    assign trig_dir = trig_dir_t'(ctrl[`ACQ_TRIG_LSB +: 2]);
    assign src = input_src_t'(ctrl[`ACQ_SRC_LSB +: 3]);
    assign scan = scan_mode_t'(ctrl[`ACQ_SCAN_LSB +: 3]);
    assign irq_cond = irq_cond_t'(ctrl[`ACQ_IRQ_LSB +: 2]);
    wire timer_en = ctrl[`ACQ_TIMER_BIT];
    wire trig_in_en = (trig_dir == TRIG_IN);
    wire trig_out_en = (trig_dir == TRIG_OUT);
    wire trig_edge = trig_in_en && trig_level && !trig_prev;
    // scan codes 001..101 are live; 000, 110, 111 start nothing
    wire scan_live = (scan != SCAN_OFF) && (scan != SCAN_UNUSED6)
        && (scan != SCAN_UNUSED7);
    wire src_valid = (src != SRC_UNUSED);
    wire timer_fire = timer_en && TIMER_TICK_I && (scan != SCAN_EXT_ONLY);
    wire next_start = scan_live && src_valid
        && (timer_fire || (scan == SCAN_EXT_ONLY) && trig_edge);
    wire irq_event = ((irq_cond == IRQ_EACH) && CONV_DONE_I)
        || ((irq_cond == IRQ_GROUP) && GROUP_DONE_I);
    wire release_req = wr_isr && BE_I[1] && WDATA_I[`ACQ_ISR_REL_BIT];
    wire next_int_en = (wr_isr && BE_I[0]) ? WDATA_I[`ACQ_ISR_EN_BIT]
        : int_en;
    // straight binary is two's complement with the sign bit flipped
    wire [15:0] next_result = fmt_straight ? {~RAW_I[15], RAW_I[14:0]}
        : RAW_I;
    wire [15:0] rd_mux = hit_ctrl ? (ctrl & `ACQ_CTRL_RMASK)
        : hit_isr ? {14'h0000, irq_state == IRQ_HELD, int_en}
        : 16'h0000;
    // calibration codes 011..111 route references or zero, not field pins
    wire cal_sel = (src >= SRC_CAL_4V9);

    // ************************************************************
    // interrupt hold machine
    // ************************************************************
    always_comb begin
        next_irq_state = irq_state;
        case (irq_state)
            IRQ_IDLE: begin
                if (irq_event) begin
                    next_irq_state = IRQ_HELD;
                end
            end
            IRQ_HELD: begin
                // a fresh event in the release cycle keeps the request
                if ((release_req || !next_int_en) && !irq_event) begin
                    next_irq_state = IRQ_IDLE;
                end
            end
            default: begin
                next_irq_state = IRQ_IDLE;
            end
        endcase
    end

    acq_pin_sync trig_sync (
        .clk_i(CLOCK_I),
        .rstn_i(RSTN_I),
        .pin_i(TRIG_PIN_I),
        .level_o(trig_level)
    );

    // ************************************************************
    // flops
    // ************************************************************
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            ctrl <= `ACQ_CTRL_RESET;
            int_en <= 1'b0;
            irq_state <= IRQ_IDLE;
        end else begin
            if (wr_ctrl) begin
                ctrl <= next_ctrl;
            end
            int_en <= next_int_en;
            irq_state <= next_irq_state;
        end
    end

    // ************************************************************
    // edge memory and registered outputs
    // ************************************************************
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_level;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 16'h0000;
        end else begin
            RDATA_O <= RD_I ? rd_mux : 16'h0000;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            RESULT_O <= 16'h0000;
        end else begin
            RESULT_O <= next_result;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            SRC_SEL_O <= 3'h0;
            CAL_SEL_O <= 1'b0;
        end else begin
            SRC_SEL_O <= src;
            CAL_SEL_O <= cal_sel;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            TRIG_PIN_O <= 1'b0;
            TRIG_PIN_OEN_O <= 1'b1;
        end else begin
            // master card echoes its start pulses onto the shared line
            TRIG_PIN_O <= trig_out_en && next_start;
            TRIG_PIN_OEN_O <= !trig_out_en;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            CONV_START_O <= 1'b0;
            SCAN_ACTIVE_O <= 1'b0;
        end else begin
            CONV_START_O <= next_start;
            SCAN_ACTIVE_O <= scan_live && src_valid;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= (next_irq_state == IRQ_HELD) && next_int_en;
        end
    end
endmodule

// ---- tb/acq_host_model.sv ----
// host-side bus model issuing register reads and writes
`timescale 1ns/1ps
module acq_host_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o,
    output logic [1:0] be_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        {addr_o, wdata_o, be_o, wr_o, rd_o} = '0;
    end
    // strobes last one cycle; the next access waits for a fresh edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] b);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        be_o <= b;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule

// ---- tb/acq_ctrl_asserts.sv ----
// assertions on the acquisition control ports
`timescale 1ns/1ps
module acq_ctrl_asserts (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic CONV_DONE_I,
    input wire logic GROUP_DONE_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [15:0] RAW_I,
    input wire logic [15:0] RDATA_O,
    input wire logic [15:0] RESULT_O,
    input wire logic [2:0] SRC_SEL_O,
    input wire logic CAL_SEL_O,
    input wire logic TRIG_PIN_O,
    input wire logic TRIG_PIN_OEN_O,
    input wire logic CONV_START_O,
    input wire logic SCAN_ACTIVE_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    chk_reset_quiet: assert property (
        $rose(RSTN_I) |-> !IRQ_O && TRIG_PIN_OEN_O && !CONV_START_O)
        else $error("outputs busy after reset");
    chk_unused_bits: assert property (
        RD_I && ADDR_I == 8'h04 |=> (RDATA_O & 16'hc0c0) == 16'h0000)
        else $error("unused control bits read nonzero");
    chk_result_low: assert property (
        1'b1 |=> RESULT_O[14:0] == $past(RAW_I[14:0]))
        else $error("result low bits altered");
    chk_drive_enabled: assert property (TRIG_PIN_O |-> !TRIG_PIN_OEN_O)
        else $error("trigger driven while released");
    chk_drive_start: assert property (
        CONV_START_O && !TRIG_PIN_OEN_O |-> TRIG_PIN_O)
        else $error("start not sent on trigger line");
    chk_cal_select: assert property (
        CAL_SEL_O == (SRC_SEL_O >= 3'h3))
        else $error("calibration select wrong");
    chk_unused_src: assert property (
        SRC_SEL_O == 3'h2 |-> !SCAN_ACTIVE_O)
        else $error("scan active on unused source");
    chk_irq_hold: assert property (IRQ_O && !WR_I |=> IRQ_O)
        else $error("request dropped without write");
    chk_irq_cause: assert property ($rose(IRQ_O) |->
        $past(CONV_DONE_I) || $past(GROUP_DONE_I) || $past(WR_I))
        else $error("request raised without event");
endmodule
bind acq_ctrl acq_ctrl_asserts u_chk (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
    .WR_I(WR_I), .RD_I(RD_I), .CONV_DONE_I(CONV_DONE_I),
    .GROUP_DONE_I(GROUP_DONE_I), .ADDR_I(ADDR_I), .RAW_I(RAW_I),
    .RDATA_O(RDATA_O), .RESULT_O(RESULT_O), .SRC_SEL_O(SRC_SEL_O),
    .CAL_SEL_O(CAL_SEL_O), .TRIG_PIN_O(TRIG_PIN_O),
    .TRIG_PIN_OEN_O(TRIG_PIN_OEN_O), .CONV_START_O(CONV_START_O),
    .SCAN_ACTIVE_O(SCAN_ACTIVE_O), .IRQ_O(IRQ_O));

// ---- tb/adc_acq_tb_top.sv ----
// self-checking bench for the acquisition control block
`timescale 1ns/1ps
module adc_acquisition_control_register_tb_top;
    logic clk, rstn, wr, rd, cdone, gdone, tick, tpin;
    logic cal, tout, toen, start, active, irq;
    logic [7:0] addr;
    logic [15:0] wdata, raw, rdata, result;
    logic [1:0] be;
    logic [2:0] src;
    int err_count, n_tests, cyc, i;
    acq_ctrl dut (.CLOCK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
        .WDATA_I(wdata), .BE_I(be), .WR_I(wr), .RD_I(rd),
        .CONV_DONE_I(cdone), .GROUP_DONE_I(gdone), .TIMER_TICK_I(tick),
        .RAW_I(raw), .TRIG_PIN_I(tpin), .RDATA_O(rdata),
        .RESULT_O(result), .SRC_SEL_O(src), .CAL_SEL_O(cal),
        .TRIG_PIN_O(tout), .TRIG_PIN_OEN_O(toen), .CONV_START_O(start),
        .SCAN_ACTIVE_O(active), .IRQ_O(irq));
    acq_host_model u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .be_o(be), .wr_o(wr), .rd_o(rd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // a hang costs a mismatch instead of an endless run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_host.rd(a, d);
        chk("rdata", e, d);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one-cycle pulse on {group done, conv done, timer tick}
    task automatic ev(input logic [2:0] v);
        @(posedge clk) {gdone, cdone, tick} <= v;
        @(posedge clk) {gdone, cdone, tick} <= 3'h0;
        #1;
    endtask
    task automatic close_out();
        $display("mismatches %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {rstn, cdone, gdone, tick, tpin, raw} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdc(8'h04, 16'h0000);
        chk("oen", 16'h1, toen);
        u_host.wr(8'h04, 16'hffff, 2'h3);
        rdc(8'h04, 16'h3f3f);
        u_host.wr(8'h04, 16'h0000, 2'h1);
        rdc(8'h04, 16'h3f00);
        rdc(8'h08, 16'h0000);
        u_host.wr(8'h04, 16'h0001, 2'h3);
        raw <= 16'h7fff;
        wt(2);
        chk("result", 16'hffff, result);
        u_host.wr(8'h04, 16'h0000, 2'h3);
        wt(2);
        chk("result", 16'h7fff, result);
        for (i = 0; i < 8; i++) begin
            u_host.wr(8'h04, 16'((i << 8) | (i << 3)), 2'h3);
            wt(2);
            chk("src", 16'(i), 16'(src));
            chk("cal", 16'(i >= 3), 16'(cal));
            chk("act", 16'(i inside {1, [3:5]}), 16'(active));
        end
        u_host.wr(8'h04, 16'h0904, 2'h3);
        wt(2);
        chk("oen", 16'h0, toen);
        ev(3'h1);
        chk("start", 16'h1, start);
        chk("tpin", 16'h1, tout);
        u_host.wr(8'h04, 16'h0104, 2'h3);
        ev(3'h1);
        chk("start", 16'h0, start);
        u_host.wr(8'h04, 16'h0502, 2'h3);
        @(posedge clk) tpin <= 1'b1;
        for (i = 0; i < 10 && start !== 1'b1; i++) wt(1);
        chk("ext start", 16'h1, start);
        @(posedge clk) tpin <= 1'b0;
        u_host.wr(8'h00, 16'h0001, 2'h1);
        u_host.wr(8'h04, 16'h1000, 2'h3);
        ev(3'h2);
        wt(3);
        chk("irq", 16'h1, irq);
        u_host.wr(8'h00, 16'h8001, 2'h3);
        wt(1);
        chk("irq", 16'h0, irq);
        u_host.wr(8'h04, 16'h2000, 2'h3);
        ev(3'h2);
        chk("irq", 16'h0, irq);
        ev(3'h4);
        chk("irq", 16'h1, irq);
        u_host.wr(8'h00, 16'h0000, 2'h1);
        wt(1);
        chk("irq", 16'h0, irq);
        u_host.wr(8'h00, 16'h0001, 2'h1);
        u_host.wr(8'h04, 16'h3000, 2'h3);
        ev(3'h6);
        chk("irq", 16'h0, irq);
        u_host.wr(8'h04, 16'h0000, 2'h2);
        ev(3'h6);
        chk("irq", 16'h0, irq);
        u_host.wr(8'h04, 16'h1000, 2'h2);
        ev(3'h2);
        chk("irq", 16'h1, irq);
        // second reset while a request is held must clear it all
        @(posedge clk) rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdc(8'h04, 16'h0000);
        rdc(8'h00, 16'h0000);
        chk("irq", 16'h0, irq);
        close_out();
    end
endmodule
